// file: src/pmw_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "pmw_consts.vh"
module pmw_ctrl #(
   parameter STAB_W = 11
) (
   input  wire       clk_sys,
   input  wire       rstn,
   input  wire [3:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   input  wire       halt_req,
   input  wire       wake_port_fall,
   input  wire       wake_irq,
   input  wire       wdt_overflow,
   input  wire       clr_wdt,
   input  wire       hs_osc_tick,
   input  wire       sub_osc_tick,
   output reg        hs_osc_en,
   output reg        sub_osc_en,
   output reg        fh_div_run,
   output reg  [1:0] sys_clk_src,
   output reg  [2:0] sys_div_shift,
   output reg        sys_clk_gate,
   output reg        cpu_run,
   output reg        wdt_clear,
   output reg        wdt_run,
   output reg        wdt_reset,
   output reg  [2:0] power_state,
   output reg        fast_wake_active
);
   localparam ST_RUN  = 3'h0;
   localparam ST_DEEP = 3'h1;
   localparam ST_SUBS = 3'h2;
   localparam ST_OFFW = 3'h3;
   localparam ST_ONW  = 3'h4;
   localparam ST_WAKE = 3'h5;
   localparam ST_FAST = 3'h6;

   reg  [7:0] system_mode_reg;
   reg  [7:0] ctrl_reg;
   reg  [7:0] cfg_reg;
   reg        power_down_flag_reg;
   reg        watchdog_timeout_flag_reg;
   reg  [2:0] state_reg;
   reg  [2:0] state_next;
   reg        wk_need_hs_reg;
   reg        wk_need_ls_reg;
   reg        wk_count_reg;
   reg        wk_on_hs_reg;
   reg        wk_fast_reg;
   reg  [1:0] wk_cnt_reg;
   reg  [5:0] div_cnt_reg;
   reg  [1:0] req_src;
   reg        hs_en_next;
   reg        sub_en_next;
   reg        wdt_run_next;

   wire       hl_sel   = system_mode_reg[`PMW_MODE_HLSEL];
   wire       idle_en  = system_mode_reg[`PMW_MODE_IDLE_ENABLE];
   wire       fast_en  = system_mode_reg[`PMW_MODE_FAST];
   wire [2:0] div_fld  = system_mode_reg[`PMW_MODE_DIV_LO+2:`PMW_MODE_DIV_LO];
   wire       syson    = ctrl_reg[`PMW_CTRL_SYSON];
   wire       hs_is_rc = cfg_reg[`PMW_CFG_HS_RC];
   wire       sub_xt   = cfg_reg[`PMW_CFG_SUB_XT];
   wire       wdt_en   = cfg_reg[`PMW_CFG_WDT_EN];
   wire       wdt_sub  = cfg_reg[`PMW_CFG_WDT_SUB];
   wire       vd_en    = cfg_reg[`PMW_CFG_VD_EN];
   wire       want_sub = !hl_sel && div_fld[2:1] == 2'b00;
   wire       wake_any = wake_port_fall || wake_irq || wdt_overflow;
   wire       hs_ready;
   wire       ls_ready;
   wire [1:0] cur_src;
   wire       gate_on;
   wire [2:0] div_shift = 3'h0 - div_fld;
   wire       div_tick  = hs_osc_tick && ((div_cnt_reg | ~((6'h01 << div_shift) - 6'h01)) == 6'h3F);
   wire       wk_tick   = wk_on_hs_reg ? hs_osc_tick : sub_osc_tick;
   wire       wk_done   = (!wk_need_hs_reg || hs_ready) && (!wk_need_ls_reg || ls_ready) &&
                          (!wk_count_reg || {9'h000, wk_cnt_reg} == `PMW_RC_WAKE);
   wire       halt_ok   = halt_req && state_reg == ST_RUN;

   // High-speed stabilisation: crystal 1024 cycles, RC 16 edges (15-16 cycles).
   pmw_stab_counter #(.WIDTH(STAB_W)) u_hs_stab (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .run     (hs_osc_en),
      .tick    (hs_osc_tick),
      .target  (hs_is_rc ? `PMW_HRC_STAB : `PMW_XT_STAB),
      .done    (hs_ready)
   );

   pmw_stab_counter #(.WIDTH(STAB_W)) u_ls_stab (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .run     (sub_osc_en),
      .tick    (sub_osc_tick),
      .target  (sub_xt ? `PMW_XT_STAB : `PMW_RC_WAKE),
      .done    (ls_ready)
   );

   pmw_clk_switch u_switch (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .req_src  (req_src),
      .fh_tick  (hs_osc_tick),
      .div_tick (div_tick),
      .sub_tick (sub_osc_tick),
      .cur_src  (cur_src),
      .gate_on  (gate_on)
   );

   // Requested source; a switch waits for the target oscillator to be stable, except in fast run, which requests the sub clock without a ready check.
   always @* begin
      req_src = cur_src;
      if (state_reg == ST_FAST) begin
         req_src = `PMW_SRC_SUB;
      end else if (want_sub) begin
         if (ls_ready) begin
            req_src = `PMW_SRC_SUB;
         end
      end else if (hs_ready) begin
         req_src = hl_sel ? `PMW_SRC_FH : `PMW_SRC_DIV;
      end
   end

   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (halt_req) begin
               if (!idle_en) begin
                  state_next = (wdt_en || vd_en) ? ST_SUBS : ST_DEEP;
               end else begin
                  state_next = syson ? ST_ONW : ST_OFFW;
               end
            end
         end
         ST_DEEP, ST_SUBS, ST_OFFW, ST_ONW: begin
            if (wake_any) begin
               state_next = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (wk_done) begin
               state_next = wk_fast_reg ? ST_FAST : ST_RUN;
            end
         end
         ST_FAST: begin
            if (hs_ready) begin
               state_next = ST_RUN;
            end
         end
         default: state_next = ST_RUN;
      endcase
   end

   always @* begin
      sub_en_next  = state_next != ST_DEEP;
      hs_en_next   = 1'b1;
      wdt_run_next = wdt_en;
      case (state_next)
         ST_DEEP: begin
            hs_en_next   = 1'b0;
            wdt_run_next = 1'b0;
         end
         ST_SUBS, ST_OFFW: begin
            hs_en_next   = 1'b0;
            wdt_run_next = wdt_en && wdt_sub;
         end
         ST_ONW: begin
            hs_en_next   = !(want_sub && cur_src == `PMW_SRC_SUB);
            wdt_run_next = wdt_en;
         end
         ST_RUN: begin
            hs_en_next   = !(want_sub && cur_src == `PMW_SRC_SUB && req_src == `PMW_SRC_SUB);
         end
         default: hs_en_next = !wk_on_hs_reg ? !want_sub : 1'b1;
      endcase
   end

   always @(posedge clk_sys) begin
      if (!rstn) begin
         state_reg        <= ST_RUN;
         system_mode_reg  <= `PMW_MODE_RESET;
         ctrl_reg         <= `PMW_CTRL_RESET;
         cfg_reg          <= `PMW_CFG_RESET;
         power_down_flag_reg       <= 1'b0;
         watchdog_timeout_flag_reg <= 1'b0;
         wk_need_hs_reg   <= 1'b0;
         wk_need_ls_reg   <= 1'b0;
         wk_count_reg     <= 1'b0;
         wk_on_hs_reg     <= 1'b0;
         wk_fast_reg      <= 1'b0;
         wk_cnt_reg       <= 2'h0;
         div_cnt_reg      <= 6'h00;
         reg_rdata        <= 8'h00;
         hs_osc_en        <= 1'b1;
         sub_osc_en       <= 1'b1;
         fh_div_run       <= 1'b1;
         sys_clk_src      <= `PMW_SRC_FH;
         sys_div_shift    <= 3'h0;
         sys_clk_gate     <= 1'b0;
         cpu_run          <= 1'b0;
         wdt_clear        <= 1'b0;
         wdt_run          <= 1'b0;
         wdt_reset        <= 1'b0;
         power_state      <= ST_RUN;
         fast_wake_active <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (hs_osc_tick) begin
            div_cnt_reg <= div_cnt_reg + 6'h01;
         end
         if (reg_wr && reg_addr == `PMW_OFS_MODE) begin
            system_mode_reg <= {reg_wdata[7:4], 2'b00, reg_wdata[1:0]};
         end
         if (reg_wr && reg_addr == `PMW_OFS_CTRL) begin
            ctrl_reg <= {reg_wdata[7], 7'h00};
         end
         if (reg_wr && reg_addr == `PMW_OFS_CFG) begin
            cfg_reg <= {3'h0, reg_wdata[4:0]};
         end
         // Setting events win over a same-cycle clear instruction.
         if (halt_ok) begin
            power_down_flag_reg <= 1'b1;
         end else if (clr_wdt) begin
            power_down_flag_reg <= 1'b0;
         end
         if (wdt_overflow) begin
            watchdog_timeout_flag_reg <= 1'b1;
         end else if (halt_ok || clr_wdt) begin
            watchdog_timeout_flag_reg <= 1'b0;
         end
         if (state_reg != ST_RUN && state_reg != ST_WAKE && state_reg != ST_FAST && wake_any) begin
            wk_on_hs_reg   <= state_reg == ST_ONW && cur_src != `PMW_SRC_SUB;
            wk_count_reg   <= state_reg == ST_ONW || cur_src == `PMW_SRC_SUB ||
                              (state_reg != ST_DEEP && hs_is_rc == 1'b0 && fast_en);
            wk_need_ls_reg <= cur_src == `PMW_SRC_SUB && state_reg == ST_DEEP;
            wk_need_hs_reg <= cur_src != `PMW_SRC_SUB && state_reg != ST_ONW &&
                              !(fast_en && !hs_is_rc && (state_reg == ST_SUBS || state_reg == ST_OFFW));
            wk_fast_reg    <= fast_en && !hs_is_rc && cur_src != `PMW_SRC_SUB &&
                              (state_reg == ST_SUBS || state_reg == ST_OFFW);
            wk_cnt_reg     <= 2'h0;
         end else if (state_reg == ST_WAKE && wk_tick && {9'h000, wk_cnt_reg} != `PMW_RC_WAKE) begin
            wk_cnt_reg <= wk_cnt_reg + 2'h1;
         end
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `PMW_OFS_MODE: reg_rdata <= {system_mode_reg[7:4], ls_ready, hs_ready, system_mode_reg[1:0]};
               `PMW_OFS_CTRL: reg_rdata <= ctrl_reg;
               `PMW_OFS_STAT: reg_rdata <= {1'b0, cur_src, state_reg, watchdog_timeout_flag_reg,
                                            power_down_flag_reg};
               `PMW_OFS_CFG:  reg_rdata <= cfg_reg;
               default:       reg_rdata <= 8'h00;
            endcase
         end
         hs_osc_en        <= hs_en_next;
         fh_div_run       <= hs_en_next;
         sub_osc_en       <= sub_en_next;
         sys_clk_src      <= cur_src;
         sys_div_shift    <= cur_src == `PMW_SRC_DIV ? div_shift : 3'h0;
         sys_clk_gate     <= gate_on && (state_next == ST_RUN || state_next == ST_FAST ||
                                         state_next == ST_ONW);
         cpu_run          <= state_next == ST_RUN || state_next == ST_FAST;
         wdt_clear        <= halt_ok;
         wdt_run          <= wdt_run_next;
         wdt_reset        <= wdt_overflow && state_reg != ST_RUN && state_reg != ST_WAKE &&
                             state_reg != ST_FAST;
         power_state      <= state_next;
         fast_wake_active <= state_next == ST_FAST;
      end
   end
endmodule // pmw_ctrl
`default_nettype wire

// file: src/pmw_consts.vh
`ifndef PMW_CONSTS_VH
`define PMW_CONSTS_VH

`define PMW_ADDR_W          4
`define PMW_OFS_MODE        4'h0
`define PMW_OFS_CTRL        4'h4
`define PMW_OFS_STAT        4'h8
`define PMW_OFS_CFG         4'hC

`define PMW_MODE_HLSEL      0
`define PMW_MODE_IDLE_ENABLE      1
`define PMW_MODE_HSRDY      2
`define PMW_MODE_LSRDY      3
`define PMW_MODE_FAST       4
`define PMW_MODE_DIV_LO     5
`define PMW_MODE_RESET      8'h01
`define PMW_CTRL_SYSON      7
`define PMW_CTRL_RESET      8'h00
`define PMW_CFG_HS_RC       0
`define PMW_CFG_SUB_XT      1
`define PMW_CFG_WDT_EN      2
`define PMW_CFG_WDT_SUB     3
`define PMW_CFG_VD_EN       4
`define PMW_CFG_RESET       8'h0C

`define PMW_SRC_FH          2'h0
`define PMW_SRC_DIV         2'h1
`define PMW_SRC_SUB         2'h2

`define PMW_XT_STAB         11'h400
`define PMW_HRC_STAB        11'h010
`define PMW_RC_WAKE         11'h002

`endif

// file: src/pmw_stab_counter.v
`timescale 1ns/1ps
`default_nettype none
// Counts oscillator ticks while the oscillator runs; done once target is reached.
module pmw_stab_counter #(
   parameter WIDTH = 11
) (
   input  wire             clk_sys,
   input  wire             rstn,
   input  wire             run,
   input  wire             tick,
   input  wire [WIDTH-1:0] target,
   output reg              done
);
   reg [WIDTH-1:0] cnt_reg;

   always @(posedge clk_sys) begin
      if (!rstn || !run) begin
         cnt_reg <= {WIDTH{1'b0}};
         done    <= 1'b0;
      end else if (tick && !done) begin
         cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
         done    <= (cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1}) >= target;
      end
   end
endmodule // pmw_stab_counter
`default_nettype wire

// file: src/pmw_clk_switch.v
`timescale 1ns/1ps
`default_nettype none
`include "pmw_consts.vh"
// Break-before-make source switch: the gate closes at the end of an old-source
// period and reopens on a new-source edge, so no runt pulse reaches the core.
module pmw_clk_switch (
   input  wire       clk_sys,
   input  wire       rstn,
   input  wire [1:0] req_src,
   input  wire       fh_tick,
   input  wire       div_tick,
   input  wire       sub_tick,
   output reg  [1:0] cur_src,
   output reg        gate_on
);
   function tick_of;
      input [1:0] src;
      input       t_fh;
      input       t_div;
      input       t_sub;
      begin
         case (src)
            `PMW_SRC_FH:  tick_of = t_fh;
            `PMW_SRC_DIV: tick_of = t_div;
            default:      tick_of = t_sub;
         endcase
      end
   endfunction

   reg [1:0] new_src_reg;

   always @(posedge clk_sys) begin
      if (!rstn) begin
         cur_src     <= `PMW_SRC_FH;
         gate_on     <= 1'b1;
         new_src_reg <= `PMW_SRC_FH;
      end else if (gate_on) begin
         if (req_src != cur_src && tick_of(cur_src, fh_tick, div_tick, sub_tick)) begin
            gate_on     <= 1'b0;
            new_src_reg <= req_src;
         end
      end else if (cur_src != new_src_reg) begin
         // The source moves while the gate is still shut; the gate opens on a later edge.
         if (tick_of(new_src_reg, fh_tick, div_tick, sub_tick)) begin
            cur_src <= new_src_reg;
         end
      end else if (tick_of(cur_src, fh_tick, div_tick, sub_tick)) begin
         gate_on <= 1'b1;
      end
   end
endmodule // pmw_clk_switch
`default_nettype wire

// file: testbench/pmw_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_ctrl_props (
   input wire logic       clk_sys,
   input wire logic       rstn,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       halt_req,
   input wire logic       wake_irq,
   input wire logic       wdt_overflow,
   input wire logic       hs_osc_en,
   input wire logic       sub_osc_en,
   input wire logic [1:0] sys_clk_src,
   input wire logic       sys_clk_gate,
   input wire logic       cpu_run,
   input wire logic       wdt_clear,
   input wire logic       wdt_run,
   input wire logic       wdt_reset,
   input wire logic [2:0] power_state,
   input wire logic       fast_wake_active
);
   logic from_deep_reg;
   // Remembers that the current wake-up began in deep stop.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         from_deep_reg <= 1'b0;
      end else if (power_state == 3'h1) begin
         from_deep_reg <= 1'b1;
      end else if (power_state == 3'h0) begin
         from_deep_reg <= 1'b0;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   chk_halt_enters_sleep: assert property (halt_req && power_state == 3'h0 && cpu_run
      |=> power_state inside {[3'h1:3'h4]} && !cpu_run) else $error("halt did not enter a low-power state");
   chk_halt_clears_wdt: assert property (halt_req && power_state == 3'h0 && cpu_run |=> wdt_clear)
      else $error("halt did not clear the watchdog");
   chk_deep_stops_all: assert property (power_state == 3'h1 && $past(power_state) == 3'h1
      |-> !sub_osc_en && !wdt_run) else $error("deep stop left sub clock or watchdog running");
   chk_deep_no_fast: assert property (from_deep_reg |-> power_state != 3'h6)
      else $error("fast run entered after deep stop");
   chk_wdt_wake_reset: assert property (wdt_overflow && power_state inside {[3'h2:3'h4]} |=> wdt_reset)
      else $error("overflow in low power gave no watchdog reset");
   chk_wake_starts: assert property (wake_irq && power_state inside {[3'h1:3'h4]} |=> power_state == 3'h5)
      else $error("interrupt did not start wake-up");
   chk_fast_cpu_run: assert property (fast_wake_active && $past(fast_wake_active)
      |-> cpu_run && hs_osc_en) else $error("fast run stopped cpu or high-speed oscillator");
   chk_fast_on_sub: assert property ($rose(fast_wake_active) |-> ##[1:24] sys_clk_src == 2'h2)
      else $error("fast run not on sub clock");
   chk_switch_gated: assert property ($changed(sys_clk_src) |-> !sys_clk_gate)
      else $error("clock source changed with gate open");
   chk_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
endmodule // pmw_ctrl_props
bind pmw_ctrl pmw_ctrl_props u_props (.clk_sys(clk_sys), .rstn(rstn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .halt_req(halt_req), .wake_irq(wake_irq), .wdt_overflow(wdt_overflow), .hs_osc_en(hs_osc_en),
   .sub_osc_en(sub_osc_en), .sys_clk_src(sys_clk_src), .sys_clk_gate(sys_clk_gate), .cpu_run(cpu_run),
   .wdt_clear(wdt_clear), .wdt_run(wdt_run), .wdt_reset(wdt_reset), .power_state(power_state),
   .fast_wake_active(fast_wake_active));
`default_nettype wire

// file: testbench/pmw_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmw_consts.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
   $display("mismatch %s exp %0h seen %0h", nm, e, g); end end
module pmw_ctrl_tb;
   logic       clk_sys, rstn, reg_wr, reg_rd, halt_req, wake_port_fall, wake_irq, wdt_overflow, clr_wdt;
   logic       hs_osc_tick, sub_osc_tick, hs_osc_en, sub_osc_en, fh_div_run, sys_clk_gate, cpu_run;
   logic       wdt_clear, wdt_run, wdt_reset, fast_wake_active, saw_fast;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd_val;
   logic [1:0] sys_clk_src;
   logic [2:0] sys_div_shift, power_state, tick_cnt;
   int         failures, total_checks, nticks;
   pmw_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_req(halt_req), .wake_port_fall(wake_port_fall),
      .wake_irq(wake_irq), .wdt_overflow(wdt_overflow), .clr_wdt(clr_wdt), .hs_osc_tick(hs_osc_tick),
      .sub_osc_tick(sub_osc_tick), .hs_osc_en(hs_osc_en), .sub_osc_en(sub_osc_en), .fh_div_run(fh_div_run),
      .sys_clk_src(sys_clk_src), .sys_div_shift(sys_div_shift), .sys_clk_gate(sys_clk_gate), .cpu_run(cpu_run),
      .wdt_clear(wdt_clear), .wdt_run(wdt_run), .wdt_reset(wdt_reset), .power_state(power_state),
      .fast_wake_active(fast_wake_active));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // Oscillators tick only while enabled: high speed every 2 cycles, sub every 8.
   always @(posedge clk_sys) begin
      tick_cnt <= tick_cnt + 3'h1;
      hs_osc_tick <= hs_osc_en & tick_cnt[0];
      sub_osc_tick <= sub_osc_en & (tick_cnt == 3'h7);
   end
   task finish_test;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
   endtask
   task pulse(input int which);
      @(posedge clk_sys);
      case (which)
         0: halt_req <= 1'b1;
         1: wake_port_fall <= 1'b1;
         2: wake_irq <= 1'b1;
         3: wdt_overflow <= 1'b1;
         default: clr_wdt <= 1'b1;
      endcase
      @(posedge clk_sys);
      {halt_req, wake_port_fall, wake_irq, wdt_overflow, clr_wdt} <= 5'h00;
   endtask
   // Waits for power_state (kind 0) or sys_clk_src (kind 1) to reach v.
   task wait_for(input int kind, input logic [2:0] v);
      int i;
      i = 0;
      while ((kind == 0 ? power_state : {1'b0, sys_clk_src}) !== v && i < 5000) begin
         @(posedge clk_sys);
         #1 i++;
         if (power_state === 3'h6) saw_fast = 1'b1;
         if ((power_state === 3'h5 || power_state === 3'h6) && hs_osc_tick === 1'b1) nticks++;
      end
      if (i >= 5000) begin
         failures++;
         $display("mismatch wait exp %0h", v);
         finish_test();
      end
   endtask
   task t_regs;
      rd(`PMW_OFS_CTRL);
      `CHK("ctrl reset", 8'h00, rd_val)
      rd(`PMW_OFS_CFG);
      `CHK("cfg reset", 8'h0C, rd_val)
      rd(4'h2);
      `CHK("unmapped", 8'h00, rd_val)
      wr(`PMW_OFS_STAT, 8'hFF);
      rd(`PMW_OFS_STAT);
      `CHK("status ro", 2'b00, rd_val[1:0])
      wr(`PMW_OFS_MODE, 8'h11);
      rd(`PMW_OFS_MODE);
      `CHK("mode fast bit", 8'h11, rd_val & 8'hF3)
   endtask
   task t_halt(input logic [7:0] md, ct, cf, input logic [2:0] st, input logic fast, input int src, lo, hi);
      wr(`PMW_OFS_MODE, md);
      wr(`PMW_OFS_CTRL, ct);
      wr(`PMW_OFS_CFG, cf);
      pulse(0);
      #1 `CHK("halt state", st, power_state)
      `CHK("halt cpu", 1'b0, cpu_run)
      if (st == 3'h1) `CHK("deep osc wdt", 2'b00, {sub_osc_en, wdt_run})
      rd(`PMW_OFS_STAT);
      `CHK("sleep flags", 2'b01, rd_val[1:0])
      nticks = 0;
      saw_fast = 1'b0;
      pulse(src);
      wait_for(0, 3'h0);
      `CHK("fast wake", fast, saw_fast)
      `CHK("wake ticks", 1'b1, nticks >= lo && nticks <= hi)
      `CHK("wake cpu", 1'b1, cpu_run)
   endtask
   task t_wdt;
      wr(`PMW_OFS_MODE, 8'h01);
      wr(`PMW_OFS_CFG, 8'h0C);
      pulse(0);
      pulse(3);
      #1 `CHK("wdt reset", 1'b1, wdt_reset)
      wait_for(0, 3'h0);
      rd(`PMW_OFS_STAT);
      `CHK("timeout flag", 2'b11, rd_val[1:0])
   endtask
   task t_slow;
      wr(`PMW_OFS_CFG, 8'h0C);
      wr(`PMW_OFS_MODE, 8'h00);
      wait_for(1, 3'h2);
      `CHK("slow osc", 2'b00, {hs_osc_en, fh_div_run})
      rd(`PMW_OFS_MODE);
      `CHK("ls ready", 1'b1, rd_val[3])
      for (int d = 2; d < 8; d++) begin
         wr(`PMW_OFS_MODE, {d[2:0], 5'h00});
         wait_for(1, 3'h1);
         @(posedge clk_sys);
         #1;
         `CHK("div shift", 3'(8 - d), sys_div_shift)
         rd(`PMW_OFS_MODE);
         `CHK("hs ready", 1'b1, rd_val[2])
      end
      wr(`PMW_OFS_MODE, 8'h01);
      wait_for(1, 3'h0);
      pulse(4);
      rd(`PMW_OFS_STAT);
      `CHK("flags cleared", 2'b00, rd_val[1:0])
   endtask
   initial begin
      {rstn, reg_wr, reg_rd, halt_req, wake_port_fall, wake_irq, wdt_overflow, clr_wdt} = 8'h00;
      {reg_addr, reg_wdata, tick_cnt, hs_osc_tick, sub_osc_tick} = 17'h00000;
      failures = 0;
      total_checks = 0;
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (2) @(posedge clk_sys);
      t_regs();
      t_wdt();
      t_halt(8'h01, 8'h00, 8'h00, 3'h1, 1'b0, 1, 1020, 1030);
      t_halt(8'h11, 8'h00, 8'h00, 3'h1, 1'b0, 2, 1020, 1030);
      t_halt(8'h11, 8'h00, 8'h0C, 3'h2, 1'b1, 1, 1020, 1030);
      t_halt(8'h13, 8'h00, 8'h0C, 3'h3, 1'b1, 2, 1020, 1030);
      t_halt(8'h13, 8'h80, 8'h0C, 3'h4, 1'b0, 1, 0, 4);
      t_halt(8'h11, 8'h00, 8'h0D, 3'h2, 1'b0, 2, 14, 18);
      t_halt(8'h01, 8'h00, 8'h10, 3'h2, 1'b0, 1, 1020, 1030);
      t_slow();
      finish_test();
   end
endmodule // pmw_ctrl_tb
`default_nettype wire
